// ### hw/ievs_pkg.sv
package ievs_pkg;
    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0]  ADDR_STATUS      = 8'h00;
    localparam logic [7:0]  ADDR_MASK        = 8'h04;
    localparam logic [7:0]  ADDR_RXCTRL      = 8'h08;
    localparam logic [7:0]  ADDR_TXCAUSE     = 8'h0c;
    localparam int          ADDR_W           = 8;
    localparam int          NFLAGS           = 9;
    localparam logic [8:0]  FLAGS_RESET      = 9'h000;
    localparam logic [8:0]  MASK_RESET       = 9'h000;
    // ********************************************************************
    // Status bit positions
    // ********************************************************************
    localparam int          BIT_RX_OVERRUN   = 0;
    localparam int          BIT_MISSED       = 1;
    localparam int          BIT_ALIGN        = 2;
    localparam int          BIT_CHECKSUM     = 3;
    localparam int          BIT_AREA_EXC     = 4;
    localparam int          BIT_BUF_EXH      = 5;
    localparam int          BIT_DESC_EXH     = 6;
    localparam int          BIT_TIMER        = 7;
    localparam int          BIT_TX_ERR       = 8;
    // Transmit cause bits held in the cause register.
    localparam int          CAUSE_BCM        = 0;
    localparam int          CAUSE_EXC        = 1;
    localparam int          CAUSE_UNDERRUN   = 2;
    localparam int          CAUSE_DEFER      = 3;
    // Receive control register bits.
    localparam int          RXCTRL_HALTED    = 0;
    localparam int          RXCTRL_FETCH     = 1;
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;
    localparam logic [31:0] TIMER_ZERO       = 32'h0000_0000;
    localparam logic [31:0] TIMER_ONES       = 32'hffff_ffff;
    localparam logic [15:0] TALLY_MAX        = 16'hffff;
    localparam logic [15:0] TALLY_ZERO       = 16'h0000;
endpackage

// ### hw/ievs_status.sv
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Bit 8 sets when a packet finishes with any transmit error.
// - Transmit error causes: count mismatch, collisions, underrun, deferral; cause recorded.
// - Bit 7 sets when the 32-bit timer wraps from zero to all ones.
// - Bit 6 sets when the end-of-list marker is seen in descriptors.
// - Bit 5 sets when read pointer equals write pointer after last field read.
// - Bit 5 is an early warning on reading the last resource descriptor.
// - Reception halts after last buffer; resumes after pointers advance and bit cleared.
// - Clearing bit 5 with buffers added triggers a resource descriptor fetch.
// - Bit 4 sets at buffer area end; packet aborted, next descriptors fetched.
// - After that abort, buffer space is not reused and no descriptor built.
// - Bit 3 sets when the checksum tally wraps from maximum to zero.
// - Bit 2 sets when the alignment tally wraps from maximum to zero.
// - Bit 1 sets when the missed packet tally wraps from maximum to zero.
// - Bit 0 sets when the receive FIFO overruns before bus access.
// - Transmit underrun has no own flag; only through bit 8.
// - Writing one clears a flag; writing zero leaves it.
// - Flags clear on hardware reset and hold across software reset.
// - Interrupt asserted while any flag and its mask bit are set.
module ievs_status
    import ievs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    // Event sources on the bus clock.
    input  wire logic              tx_done,
    input  wire logic              byte_count_mismatch,
    input  wire logic              excessive_collisions,
    input  wire logic              tx_fifo_underrun,
    input  wire logic              excessive_deferral,
    input  wire logic [31:0]       timer_value,
    input  wire logic              end_of_list_marker,
    input  wire logic              resource_last_field_read,
    input  wire logic [15:0]       resource_read_pointer,
    input  wire logic [15:0]       resource_write_pointer,
    input  wire logic              last_buffer_used,
    input  wire logic              rx_area_end,
    input  wire logic [15:0]       checksum_tally,
    input  wire logic [15:0]       alignment_tally,
    input  wire logic [15:0]       missed_tally,
    input  wire logic              rx_fifo_overrun,
    // Control towards the receive engine, transmit status and interrupt.
    output logic                   rx_halt,
    output logic                   read_resource_command,
    output logic                   rx_abort_packet,
    output logic                   rx_skip_descriptor,
    output logic [3:0]             tx_descriptor_status_field,
    output logic                   irq,
    // AXI4-Lite slave.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // ********************************************************************
    // Event detection
    // ********************************************************************
    logic              timer_wrap;
    logic              cks_wrap;
    logic              aln_wrap;
    logic              mis_wrap;
    logic              tx_any_err;
    logic [NFLAGS-1:0] set_vec;

    ievs_wrap_det #(.W(32), .FROM(TIMER_ZERO), .TO(TIMER_ONES)) u_timer (
        .clk   (clk),
        .nrst  (nrst),
        .value (timer_value),
        .wrap  (timer_wrap)
    );
    ievs_wrap_det #(.W(16), .FROM(TALLY_MAX), .TO(TALLY_ZERO)) u_cks (
        .clk   (clk),
        .nrst  (nrst),
        .value (checksum_tally),
        .wrap  (cks_wrap)
    );
    ievs_wrap_det #(.W(16), .FROM(TALLY_MAX), .TO(TALLY_ZERO)) u_aln (
        .clk   (clk),
        .nrst  (nrst),
        .value (alignment_tally),
        .wrap  (aln_wrap)
    );
    ievs_wrap_det #(.W(16), .FROM(TALLY_MAX), .TO(TALLY_ZERO)) u_mis (
        .clk   (clk),
        .nrst  (nrst),
        .value (missed_tally),
        .wrap  (mis_wrap)
    );

    // Underrun only reaches status through the transmit error bit.
    assign tx_any_err = byte_count_mismatch | excessive_collisions
                      | tx_fifo_underrun | excessive_deferral;

    // Set sources gathered by position.
    always_comb begin
        set_vec                 = '0;
        set_vec[BIT_TX_ERR]     = tx_done & tx_any_err;
        set_vec[BIT_TIMER]      = timer_wrap;
        set_vec[BIT_DESC_EXH]   = end_of_list_marker;
        set_vec[BIT_BUF_EXH]    = resource_last_field_read
                                & (resource_read_pointer == resource_write_pointer);
        set_vec[BIT_AREA_EXC]   = rx_area_end;
        set_vec[BIT_CHECKSUM]   = cks_wrap;
        set_vec[BIT_ALIGN]      = aln_wrap;
        set_vec[BIT_MISSED]     = mis_wrap;
        set_vec[BIT_RX_OVERRUN] = rx_fifo_overrun;
    end

    // ********************************************************************
    // Bus slave
    // ********************************************************************
    logic              aw_got_r;
    logic              aw_got_nxt;
    logic              w_got_r;
    logic              w_got_nxt;
    logic [ADDR_W-1:0] awaddr_r;
    logic [ADDR_W-1:0] awaddr_nxt;
    logic [31:0]       wdata_r;
    logic [31:0]       wdata_nxt;
    logic [3:0]        wstrb_r;
    logic [3:0]        wstrb_nxt;
    logic              bvalid_r;
    logic              bvalid_nxt;
    logic [1:0]        bresp_r;
    logic [1:0]        bresp_nxt;
    logic              rvalid_r;
    logic              rvalid_nxt;
    logic [31:0]       rdata_r;
    logic [31:0]       rdata_nxt;
    logic [1:0]        rresp_r;
    logic [1:0]        rresp_nxt;
    logic              wr_fire;

    // Both halves of a write are accepted independently and held.
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign wr_fire       = aw_got_r && w_got_r && !bvalid_r;

    // Maps a byte address onto a known register.
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a == ADDR_STATUS) || (a == ADDR_MASK)
               || (a == ADDR_RXCTRL) || (a == ADDR_TXCAUSE);
    endfunction

    // ********************************************************************
    // Flags, mask and receive control
    // ********************************************************************
    logic [NFLAGS-1:0] flags_r;
    logic [NFLAGS-1:0] flags_nxt;
    logic [NFLAGS-1:0] mask_r;
    logic [NFLAGS-1:0] mask_nxt;
    logic [3:0]        cause_r;
    logic [3:0]        cause_nxt;
    logic              halt_r;
    logic              halt_nxt;
    logic              fetch_r;
    logic              fetch_nxt;
    logic [NFLAGS-1:0] clr_vec;
    logic              buf_clear;

    // A write of ones clears; only lanes that are enabled take part.
    always_comb begin
        clr_vec = '0;
        if (wr_fire && awaddr_r == ADDR_STATUS) begin
            clr_vec[7:0] = wstrb_r[0] ? wdata_r[7:0] : 8'h00;
            clr_vec[8]   = wstrb_r[1] & wdata_r[8];
        end
    end
    assign buf_clear = clr_vec[BIT_BUF_EXH] && flags_r[BIT_BUF_EXH];

    // Register updates and receive halt logic.
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        mask_nxt   = mask_r;
        cause_nxt  = cause_r;
        halt_nxt   = halt_r;
        fetch_nxt  = 1'b0;
        // Set wins over a simultaneous clear.
        flags_nxt  = (flags_r & ~clr_vec) | set_vec;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb; // Strobes are held with the data they qualify.
        end
        if (wr_fire) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_r == ADDR_MASK && wstrb_r[0])
                mask_nxt[7:0] = wdata_r[7:0];
            if (awaddr_r == ADDR_MASK && wstrb_r[1])
                mask_nxt[8] = wdata_r[8];
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                ADDR_STATUS:  rdata_nxt = {23'h000000, flags_r};
                ADDR_MASK:    rdata_nxt = {23'h000000, mask_r};
                ADDR_RXCTRL:  rdata_nxt = {30'h00000000, fetch_r, halt_r};
                ADDR_TXCAUSE: rdata_nxt = {28'h0000000, cause_r};
                default:      rdata_nxt = 32'h0000_0000;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        // Cause of the latest failed transmission is kept for software.
        if (tx_done && tx_any_err) begin
            cause_nxt[CAUSE_BCM]      = byte_count_mismatch;
            cause_nxt[CAUSE_EXC]      = excessive_collisions;
            cause_nxt[CAUSE_UNDERRUN] = tx_fifo_underrun;
            cause_nxt[CAUSE_DEFER]    = excessive_deferral;
        end
        // Reception stops once the last buffer is gone.
        if (last_buffer_used)
            halt_nxt = 1'b1;
        // Clearing the exhausted flag with new buffers restarts reception.
        if (buf_clear && resource_write_pointer != resource_read_pointer) begin
            halt_nxt  = 1'b0;
            fetch_nxt = 1'b1;
        end
    end

    // No software reset input exists, so only nrst touches the flags.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= '0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
            flags_r  <= FLAGS_RESET;
            mask_r   <= MASK_RESET;
            cause_r  <= '0;
            halt_r   <= 1'b0;
            fetch_r  <= 1'b0;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r  <= wdata_nxt;
            wstrb_r  <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
            flags_r  <= flags_nxt;
            mask_r   <= mask_nxt;
            cause_r  <= cause_nxt;
            halt_r   <= halt_nxt;
            fetch_r  <= fetch_nxt;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;
    assign rx_halt      = halt_r;
    assign read_resource_command      = fetch_r | rx_area_end;
    // The abort drops the rest of the area and suppresses the descriptor.
    assign rx_abort_packet            = rx_area_end;
    assign rx_skip_descriptor         = rx_area_end;
    assign tx_descriptor_status_field = cause_r;
    assign irq = |(flags_r & mask_r);

    // ********************************************************************
    // Checks
    // ********************************************************************
    property p_txerr;
        @(posedge clk) disable iff (!nrst)
        (tx_done && tx_any_err) |=> flags_r[BIT_TX_ERR];
    endproperty
    a_txerr: assert property (p_txerr) else $error("tx error flag not set");

    property p_timer;
        @(posedge clk) disable iff (!nrst)
        ($past(timer_value) == TIMER_ZERO && timer_value == TIMER_ONES
         && $past(nrst)) |=> flags_r[BIT_TIMER];
    endproperty
    a_timer: assert property (p_timer) else $error("timer flag not set");

    property p_bufexh;
        @(posedge clk) disable iff (!nrst)
        (resource_last_field_read && resource_read_pointer == resource_write_pointer)
        |=> flags_r[BIT_BUF_EXH];
    endproperty
    a_bufexh: assert property (p_bufexh) else $error("buffer flag not set");

    property p_halt;
        @(posedge clk) disable iff (!nrst)
        (last_buffer_used && !fetch_nxt) |=> rx_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("reception not halted");

    property p_fetch;
        @(posedge clk) disable iff (!nrst)
        (buf_clear && resource_write_pointer != resource_read_pointer)
        |=> (read_resource_command && !rx_halt);
    endproperty
    a_fetch: assert property (p_fetch) else $error("no resource fetch");

    property p_sticky;
        @(posedge clk) disable iff (!nrst)
        (flags_r[BIT_RX_OVERRUN] && !clr_vec[BIT_RX_OVERRUN]) |=> flags_r[BIT_RX_OVERRUN];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");

    property p_clear;
        @(posedge clk) disable iff (!nrst)
        (clr_vec[BIT_MISSED] && !set_vec[BIT_MISSED]) |=> !flags_r[BIT_MISSED];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_irq;
        @(posedge clk) disable iff (!nrst)
        ((set_vec & mask_r) != '0) && !(wr_fire && awaddr_r == ADDR_MASK) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");

    property p_setwins;
        @(posedge clk) disable iff (!nrst)
        (set_vec[BIT_AREA_EXC] && clr_vec[BIT_AREA_EXC]) |=> flags_r[BIT_AREA_EXC];
    endproperty
    a_setwins: assert property (p_setwins) else $error("set lost to clear");
endmodule
`default_nettype wire

// ### hw/ievs_wrap_det.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************************
// Counter wrap detector
// ************************************************************************
module ievs_wrap_det #(
    parameter int          W    = 16,
    parameter logic [W-1:0] FROM = '1,
    parameter logic [W-1:0] TO   = '0
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] value,
    output logic              wrap
);
    logic [W-1:0] prev_r;
    logic [W-1:0] prev_nxt;
    logic         seen_r;
    logic         seen_nxt;

    // The previous value is remembered so a wrap is seen exactly once.
    always_comb begin
        prev_nxt = value;
        seen_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= '0;
            seen_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            seen_r <= seen_nxt;
        end
    end

    // The first cycle after reset has no history and cannot report a wrap.
    assign wrap = seen_r && (prev_r == FROM) && (value == TO);
endmodule
`default_nettype wire

// ### sim/ievs_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ievs_status_tb_top
    import ievs_pkg::*;
;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic        clk = 1'b0, nrst = 1'b0, tx_done = 1'b0, byte_count_mismatch = 1'b0;
    logic        excessive_collisions = 1'b0, tx_fifo_underrun = 1'b0, excessive_deferral = 1'b0;
    logic        end_of_list_marker = 1'b0, resource_last_field_read = 1'b0;
    logic        last_buffer_used = 1'b0, rx_area_end = 1'b0, rx_fifo_overrun = 1'b0;
    logic [31:0] timer_value = 32'h0000_1000;
    logic [15:0] resource_read_pointer = 16'h0005, resource_write_pointer = 16'h0005;
    logic [15:0] checksum_tally = 16'h0010, alignment_tally = 16'h0010;
    logic [15:0] missed_tally = 16'h0010;
    logic        rx_halt, read_resource_command, rx_abort_packet, rx_skip_descriptor, irq;
    logic [3:0]  tx_descriptor_status_field;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] rd, msk;
    int          error_cnt = 0, compares = 0, rcmd_cnt = 0, c0;

    ievs_status u_ievs_status (.clk, .nrst, .tx_done, .byte_count_mismatch,
        .excessive_collisions, .tx_fifo_underrun, .excessive_deferral, .timer_value,
        .end_of_list_marker, .resource_last_field_read, .resource_read_pointer,
        .resource_write_pointer, .last_buffer_used, .rx_area_end, .checksum_tally,
        .alignment_tally, .missed_tally, .rx_fifo_overrun, .rx_halt, .read_resource_command,
        .rx_abort_packet, .rx_skip_descriptor, .tx_descriptor_status_field, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    // The clock toggles every half period of 25 ns.
    initial begin
        forever #25 clk = ~clk;
    end

    // Fetch requests are counted so that a missing or doubled pulse shows up.
    always @(posedge clk) begin
        if (read_resource_command === 1'b1) rcmd_cnt++;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] flag_of(input int b);
        return 32'h0000_0001 << b;
    endfunction

    // Write and read hold every request until its ready, with a bounded wait.
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin rsp = s_axi_bresp; break; end
        end
        if (n >= 40) begin error_cnt++; test_done(); end
    endtask

    task automatic axr(input logic [7:0] a);
        int n;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin rd = s_axi_rdata; rsp = s_axi_rresp; break; end
        end
        if (n >= 40) begin error_cnt++; test_done(); end
    endtask

    // Produces the source event for one status bit, with random transmit causes.
    task automatic fire(input int b);
        case (b)
            0: rx_fifo_overrun <= 1'b1;
            1: missed_tally <= 16'hffff;
            2: alignment_tally <= 16'hffff;
            3: checksum_tally <= 16'hffff;
            4: rx_area_end <= 1'b1;
            5: resource_last_field_read <= 1'b1;
            6: end_of_list_marker <= 1'b1;
            7: timer_value <= 32'h0000_0000;
            default: begin
                tx_done <= 1'b1;
                {excessive_deferral, tx_fifo_underrun, excessive_collisions,
                    byte_count_mismatch} <= 4'($urandom_range(15, 1));
            end
        endcase
        @(posedge clk);
        {rx_fifo_overrun, rx_area_end, resource_last_field_read, end_of_list_marker} <= 4'h0;
        tx_done <= 1'b0;
        {missed_tally, alignment_tally, checksum_tally} <= 48'h0;
        timer_value <= 32'hffff_ffff;
        @(posedge clk);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(96586));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        axr(ADDR_STATUS); chk("status after reset", rd, 32'h0);
        axr(ADDR_MASK); chk("mask after reset", rd, 32'h0);
        chk("irq after reset", irq, 1'b0);
        for (int b = 0; b < NFLAGS; b++) begin
            msk = $urandom() & 32'h1ff;
            axw(ADDR_MASK, msk);
            axr(ADDR_MASK); chk("mask readback", rd, msk);
            if (b == 4) begin
                rx_area_end <= 1'b1;
                @(negedge clk);
                chk("abort with area end", {rx_abort_packet, rx_skip_descriptor,
                    read_resource_command}, 32'h7);
                @(posedge clk);
                rx_area_end <= 1'b0;
                @(posedge clk);
            end else fire(b);
            axr(ADDR_STATUS); chk("status flag", rd, flag_of(b));
            chk("irq", irq, msk[b]);
            if (b == 8) begin
                chk("tx cause", tx_descriptor_status_field, {excessive_deferral,
                    tx_fifo_underrun, excessive_collisions, byte_count_mismatch});
            end
            axw(ADDR_STATUS, ~flag_of(b) & 32'h1ff);
            axr(ADDR_STATUS); chk("status zero write", rd, flag_of(b));
            axw(ADDR_STATUS, flag_of(b));
            chk("clear resp", rsp, RESP_OKAY);
            axr(ADDR_STATUS); chk("status cleared", rd, 32'h0);
            $display("test event bit %0d done", b);
        end
        // A new event in the very cycle of its clear write keeps the flag.
        fork
            axw(ADDR_STATUS, flag_of(BIT_AREA_EXC));
            begin
                @(posedge clk);
                rx_area_end <= 1'b1;
                @(posedge clk);
                rx_area_end <= 1'b0;
            end
        join
        axr(ADDR_STATUS); chk("set beats clear", rd, flag_of(BIT_AREA_EXC));
        axw(ADDR_STATUS, 32'h1ff);
        $display("test set against clear done");
        // A finished packet without errors raises nothing; underrun only reaches bit 8.
        fire(9);
        tx_done <= 1'b1;
        {excessive_deferral, tx_fifo_underrun, excessive_collisions, byte_count_mismatch} <= 4'h0;
        @(posedge clk);
        tx_done <= 1'b0;
        @(posedge clk);
        axw(ADDR_STATUS, 32'h1ff);
        tx_done <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
        @(posedge clk);
        axr(ADDR_STATUS); chk("clean packet", rd, 32'h0);
        tx_done <= 1'b1;
        tx_fifo_underrun <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
        @(posedge clk);
        axr(ADDR_STATUS); chk("underrun flag", rd, flag_of(BIT_TX_ERR));
        chk("underrun cause", tx_descriptor_status_field, 4'h4);
        axw(ADDR_STATUS, 32'h1ff);
        $display("test transmit causes done");
        // Halt on last buffer, refused resume without buffers, resume after adding.
        last_buffer_used <= 1'b1;
        @(posedge clk);
        last_buffer_used <= 1'b0;
        @(posedge clk);
        chk("halt", rx_halt, 1'b1);
        axr(ADDR_RXCTRL); chk("rx control", rd, 32'h1);
        fire(5);
        c0 = rcmd_cnt;
        axw(ADDR_STATUS, flag_of(BIT_BUF_EXH));
        repeat (2) @(posedge clk);
        chk("halt kept", rx_halt, 1'b1);
        chk("no fetch", 32'(rcmd_cnt - c0), 32'h0);
        fire(5);
        resource_write_pointer <= 16'($urandom_range(200, 6));
        @(posedge clk);
        axw(ADDR_STATUS, flag_of(BIT_BUF_EXH));
        repeat (2) @(posedge clk);
        chk("halt released", rx_halt, 1'b0);
        chk("one fetch", 32'(rcmd_cnt - c0), 32'h1);
        $display("test buffer exhaustion done");
        // Unmapped address and a mid-run hardware reset.
        axr(8'h10); chk("unmapped read", rd, 32'h0);
        chk("unmapped read resp", rsp, RESP_SLVERR);
        axw(8'h10, 32'h1); chk("unmapped write", rsp, RESP_SLVERR);
        fire(0);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        axr(ADDR_STATUS); chk("status after reset", rd, 32'h0);
        $display("test reset and unmapped done");
        test_done();
    end
endmodule
`default_nettype wire
